// ===== src/fcsm_core.sv
// Purpose: command decoder for pin reconfig, lock setup and error recovery
// Assumes: one write cycle per valid pulse, synchronous to clk
// Notes: suspend context is set by the wider unit through susp_in
`timescale 1ns/1ps
`default_nettype none
`include "fcsm_regs.svh"

// Operation
// - erase-suspended pin setup: 0..3 applies, else error
// - program-suspended pin setup: 0..3 applies, else error
// - error state reports ready, status, normal commands
// - prog-suspended error ignores lock and protection setup
// - erase-suspended bad pin code keeps suspension
module fcsm_core (
    input wire logic clk,
    input wire logic nrst,
    input wire fcsm_pkg::fcsm_write_t wr,
    input wire fcsm_pkg::fcsm_susp_t susp_in,
    input wire logic susp_load,
    output logic [1:0] read_sel,
    output logic [1:0] pin_cfg,
    output logic ready_flag,
    output logic seq_error,
    output logic lock_go,
    output logic prot_go,
    output logic [2:0] phase,
    output logic [1:0] susp
);
    // ------------------------------------------------------------
    // state registers
    // ------------------------------------------------------------
    fcsm_pkg::fcsm_state_t st; // current state
    fcsm_pkg::fcsm_state_t next_st; // next state
    logic [7:0] cmd; // command byte

    // ------------------------------------------------------------
    // next-state decode
    // ------------------------------------------------------------
    // decode the byte against the current state
    always_comb begin
        next_st = st;
        cmd = wr.data;
        next_st.lock_go = 1'b0;
        next_st.prot_go = 1'b0;
        if (susp_load) begin
            next_st.susp = susp_in;
        end
        if (wr.valid) begin
            case (st.phase)
                fcsm_pkg::FCSM_PIN_SETUP: begin
                    // second cycle of pin reconfig
                    if (cmd <= `FCSM_PIN_CFG_MAX) begin
                        next_st.pin_cfg = cmd[1:0];
                        next_st.phase = fcsm_pkg::FCSM_READ;
                        next_st.data_sel = fcsm_pkg::FCSM_DATA_STATUS;
                    end else begin
                        // error keeps suspend context
                        next_st.phase = fcsm_pkg::FCSM_ERROR;
                        next_st.seq_error = 1'b1;
                        next_st.data_sel = fcsm_pkg::FCSM_DATA_STATUS;
                    end
                end
                fcsm_pkg::FCSM_LOCK_SETUP: begin
                    // second cycle of lock
                    if (cmd == `FCSM_LOCK_CONFIRM_A || cmd == `FCSM_LOCK_CONFIRM_B ||
                        cmd == `FCSM_LOCK_CONFIRM_C || cmd == `FCSM_LOCK_CONFIRM_D) begin
                        next_st.lock_go = 1'b1;
                        next_st.phase = fcsm_pkg::FCSM_READ;
                    end else begin
                        next_st.phase = fcsm_pkg::FCSM_ERROR;
                        next_st.seq_error = 1'b1;
                    end
                    next_st.data_sel = fcsm_pkg::FCSM_DATA_STATUS;
                end
                fcsm_pkg::FCSM_PROT_SETUP: begin
                    // data word hands off to the program engine
                    next_st.prot_go = 1'b1;
                    next_st.phase = fcsm_pkg::FCSM_READ;
                    next_st.data_sel = fcsm_pkg::FCSM_DATA_STATUS;
                end
                fcsm_pkg::FCSM_READ, fcsm_pkg::FCSM_ERROR: begin
                    // normal command set, also from error state
                    next_st.phase = fcsm_pkg::FCSM_READ;
                    case (cmd)
                        `FCSM_CMD_READ_STATUS: begin
                            next_st.data_sel = fcsm_pkg::FCSM_DATA_STATUS;
                        end
                        `FCSM_CMD_CLEAR_STATUS: begin
                            next_st.seq_error = 1'b0;
                            next_st.data_sel = fcsm_pkg::FCSM_DATA_ARRAY;
                        end
                        `FCSM_CMD_READ_CONFIG: begin
                            next_st.data_sel = fcsm_pkg::FCSM_DATA_CONFIG;
                        end
                        `FCSM_CMD_READ_QUERY: begin
                            next_st.data_sel = fcsm_pkg::FCSM_DATA_QUERY;
                        end
                        `FCSM_CMD_PIN_RECONFIG: begin
                            next_st.phase = fcsm_pkg::FCSM_PIN_SETUP;
                            next_st.data_sel = fcsm_pkg::FCSM_DATA_STATUS;
                        end
                        `FCSM_CMD_LOCK_SETUP: begin
                            // program-suspended error refuses lock
                            if (st.phase == fcsm_pkg::FCSM_ERROR &&
                                st.susp == fcsm_pkg::FCSM_SUSP_PROG) begin
                                next_st.data_sel = fcsm_pkg::FCSM_DATA_ARRAY;
                            end else begin
                                next_st.phase = fcsm_pkg::FCSM_LOCK_SETUP;
                                next_st.data_sel = fcsm_pkg::FCSM_DATA_STATUS;
                            end
                        end
                        `FCSM_CMD_PROT_SETUP: begin
                            // protection program only with nothing suspended
                            if (st.susp == fcsm_pkg::FCSM_SUSP_NONE) begin
                                next_st.phase = fcsm_pkg::FCSM_PROT_SETUP;
                                next_st.data_sel = fcsm_pkg::FCSM_DATA_STATUS;
                            end else begin
                                next_st.data_sel = fcsm_pkg::FCSM_DATA_ARRAY;
                            end
                        end
                        default: begin
                            // illegal or read array
                            next_st.data_sel = fcsm_pkg::FCSM_DATA_ARRAY;
                        end
                    endcase
                end
                default: begin
                    next_st.phase = fcsm_pkg::FCSM_READ;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    // register the whole state
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st.phase <= fcsm_pkg::FCSM_READ;
            st.susp <= fcsm_pkg::FCSM_SUSP_NONE;
            st.data_sel <= fcsm_pkg::FCSM_DATA_ARRAY;
            st.pin_cfg <= `FCSM_PIN_CFG_RESET;
            st.seq_error <= 1'b0;
            st.lock_go <= 1'b0;
            st.prot_go <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    // outputs straight from the state flops, except ready_flag which is tied high
    assign read_sel = st.data_sel;
    assign pin_cfg = st.pin_cfg;
    assign ready_flag = 1'b1; // no busy phase in this block
    assign seq_error = st.seq_error;
    assign lock_go = st.lock_go;
    assign prot_go = st.prot_go;
    assign phase = st.phase;
    assign susp = st.susp;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    // good pin code lands and selects status reads
    a_pin_good_code: assert property (@(posedge clk) disable iff (!nrst)
        (wr.valid && st.phase == fcsm_pkg::FCSM_PIN_SETUP && wr.data <= 8'h03)
        |=> (pin_cfg == $past(wr.data[1:0]) && read_sel == fcsm_pkg::FCSM_DATA_STATUS))
        else $error("pin code not applied");
    // bad pin code goes to error with context kept
    a_pin_bad_code: assert property (@(posedge clk) disable iff (!nrst)
        (wr.valid && !susp_load && st.phase == fcsm_pkg::FCSM_PIN_SETUP && wr.data > 8'h03)
        |=> (phase == fcsm_pkg::FCSM_ERROR && susp == $past(st.susp)))
        else $error("bad pin code not an error");
    // erase suspension survives any pin second cycle
    a_pin_keep_susp: assert property (@(posedge clk) disable iff (!nrst)
        (wr.valid && !susp_load && st.susp == fcsm_pkg::FCSM_SUSP_ERASE &&
         st.phase == fcsm_pkg::FCSM_PIN_SETUP) |=> susp == fcsm_pkg::FCSM_SUSP_ERASE)
        else $error("suspend lost");
    // program-suspended good pin code keeps program suspended
    a_pin_prog_good: assert property (@(posedge clk) disable iff (!nrst)
        (wr.valid && !susp_load && st.phase == fcsm_pkg::FCSM_PIN_SETUP &&
         st.susp == fcsm_pkg::FCSM_SUSP_PROG && wr.data <= `FCSM_PIN_CFG_MAX)
        |=> (phase == fcsm_pkg::FCSM_READ && susp == fcsm_pkg::FCSM_SUSP_PROG &&
             read_sel == fcsm_pkg::FCSM_DATA_STATUS))
        else $error("prog-suspended pin code not applied");
    // any other lock confirm is a sequence error
    a_lock_reject: assert property (@(posedge clk) disable iff (!nrst)
        (wr.valid && st.phase == fcsm_pkg::FCSM_LOCK_SETUP && wr.data != 8'hd0 &&
         wr.data != 8'h01 && wr.data != 8'h2f && wr.data != 8'h03)
        |=> (phase == fcsm_pkg::FCSM_ERROR && seq_error && !lock_go))
        else $error("bad lock confirm accepted");
    // erase-suspended bad lock confirm keeps the suspension
    a_lock_err_susp: assert property (@(posedge clk) disable iff (!nrst)
        (wr.valid && !susp_load && st.phase == fcsm_pkg::FCSM_LOCK_SETUP &&
         st.susp == fcsm_pkg::FCSM_SUSP_ERASE && wr.data != `FCSM_LOCK_CONFIRM_A &&
         wr.data != `FCSM_LOCK_CONFIRM_B && wr.data != `FCSM_LOCK_CONFIRM_C &&
         wr.data != `FCSM_LOCK_CONFIRM_D)
        |=> (phase == fcsm_pkg::FCSM_ERROR && susp == fcsm_pkg::FCSM_SUSP_ERASE))
        else $error("lock error dropped erase suspend");
    // a good confirm gives one start pulse
    a_lock_accept: assert property (@(posedge clk) disable iff (!nrst)
        (wr.valid && st.phase == fcsm_pkg::FCSM_LOCK_SETUP && wr.data == 8'hd0)
        |=> lock_go ##1 !lock_go)
        else $error("lock confirm not pulsed");
    // error state is ready and reads status
    a_error_status: assert property (@(posedge clk) disable iff (!nrst)
        (phase == fcsm_pkg::FCSM_ERROR) |-> (read_sel == fcsm_pkg::FCSM_DATA_STATUS && ready_flag))
        else $error("error state not status");
    // illegal byte in error state reads array
    a_error_illegal: assert property (@(posedge clk) disable iff (!nrst)
        (wr.valid && st.phase == fcsm_pkg::FCSM_ERROR && wr.data == 8'h12)
        |=> (phase == fcsm_pkg::FCSM_READ && read_sel == fcsm_pkg::FCSM_DATA_ARRAY))
        else $error("illegal not to array");
    // lock setup taken from read or a non-program error
    a_error_lock: assert property (@(posedge clk) disable iff (!nrst)
        (wr.valid && wr.data == `FCSM_CMD_LOCK_SETUP && (st.phase == fcsm_pkg::FCSM_READ ||
         (st.phase == fcsm_pkg::FCSM_ERROR && st.susp != fcsm_pkg::FCSM_SUSP_PROG)))
        |=> phase == fcsm_pkg::FCSM_LOCK_SETUP)
        else $error("lock setup not entered");
    // clear status drops the sticky error and reads array
    a_clear_status: assert property (@(posedge clk) disable iff (!nrst)
        (wr.valid && wr.data == `FCSM_CMD_CLEAR_STATUS &&
         (st.phase == fcsm_pkg::FCSM_READ || st.phase == fcsm_pkg::FCSM_ERROR))
        |=> (!seq_error && read_sel == fcsm_pkg::FCSM_DATA_ARRAY))
        else $error("clear status not applied");
    // protection data cycle gives one start pulse
    a_prot_pulse: assert property (@(posedge clk) disable iff (!nrst)
        (wr.valid && st.phase == fcsm_pkg::FCSM_PROT_SETUP)
        |=> (prot_go && phase == fcsm_pkg::FCSM_READ) ##1 !prot_go)
        else $error("protection start not pulsed");
    // program-suspended error refuses both setups
    a_prog_refuse: assert property (@(posedge clk) disable iff (!nrst)
        (wr.valid && st.phase == fcsm_pkg::FCSM_ERROR && st.susp == fcsm_pkg::FCSM_SUSP_PROG &&
         (wr.data == 8'h60 || wr.data == 8'hc0))
        |=> (phase == fcsm_pkg::FCSM_READ && read_sel == fcsm_pkg::FCSM_DATA_ARRAY))
        else $error("suspended setup honoured");
    // any suspension refuses protection setup and keeps context
    a_prot_refuse: assert property (@(posedge clk) disable iff (!nrst)
        (wr.valid && !susp_load && st.susp != fcsm_pkg::FCSM_SUSP_NONE &&
         wr.data == `FCSM_CMD_PROT_SETUP &&
         (st.phase == fcsm_pkg::FCSM_READ || st.phase == fcsm_pkg::FCSM_ERROR))
        |=> (phase == fcsm_pkg::FCSM_READ && read_sel == fcsm_pkg::FCSM_DATA_ARRAY &&
             susp == $past(st.susp)))
        else $error("suspended protection setup honoured");
    // no write, no load: state holds
    a_no_write_hold: assert property (@(posedge clk) disable iff (!nrst)
        (!wr.valid && !susp_load) |=> ($stable(phase) && $stable(read_sel) && $stable(pin_cfg)))
        else $error("state moved without write");
endmodule
`default_nettype wire

// ===== src/fcsm_pkg.sv
// Purpose: types for the flash command state machine
// Assumes: fcsm_regs.svh holds the numbers
// Notes: suspend context and read-data type are separate fields
`default_nettype none
package fcsm_pkg;
    // where the machine stands in a command sequence
    typedef enum logic [2:0] {
        FCSM_READ,
        FCSM_PIN_SETUP,
        FCSM_LOCK_SETUP,
        FCSM_PROT_SETUP,
        FCSM_ERROR
    } fcsm_phase_t;
    // which operation is suspended
    typedef enum logic [1:0] {
        FCSM_SUSP_NONE,
        FCSM_SUSP_ERASE,
        FCSM_SUSP_PROG,
        FCSM_SUSP_BOTH
    } fcsm_susp_t;
    // what a read returns
    typedef enum logic [1:0] {
        FCSM_DATA_ARRAY,
        FCSM_DATA_STATUS,
        FCSM_DATA_CONFIG,
        FCSM_DATA_QUERY
    } fcsm_data_t;
    // one host write cycle
    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } fcsm_write_t;
    // whole machine state
    typedef struct packed {
        fcsm_phase_t phase;
        fcsm_susp_t susp;
        fcsm_data_t data_sel;
        logic [1:0] pin_cfg;
        logic seq_error;
        logic lock_go;
        logic prot_go;
    } fcsm_state_t;
endpackage
`default_nettype wire

// ===== src/fcsm_regs.svh
// Purpose: constants for the flash command state machine
// Assumes: command bytes arrive on the low byte of the write data
// Notes: command codes, pin-function range and reset values
`ifndef FCSM_REGS_SVH
`define FCSM_REGS_SVH
`define FCSM_CMD_READ_ARRAY 8'hff
`define FCSM_CMD_READ_STATUS 8'h70
`define FCSM_CMD_CLEAR_STATUS 8'h50
`define FCSM_CMD_READ_CONFIG 8'h90
`define FCSM_CMD_PIN_RECONFIG 8'hb8
`define FCSM_CMD_READ_QUERY 8'h98
`define FCSM_CMD_LOCK_SETUP 8'h60
`define FCSM_CMD_PROT_SETUP 8'hc0
`define FCSM_LOCK_CONFIRM_A 8'hd0
`define FCSM_LOCK_CONFIRM_B 8'h01
`define FCSM_LOCK_CONFIRM_C 8'h2f
`define FCSM_LOCK_CONFIRM_D 8'h03
`define FCSM_PIN_CFG_MAX 8'h03
`define FCSM_PIN_CFG_RESET 2'h0
`define FCSM_PIN_CFG_W 2
`endif

// ===== tb/fcsm_host_model.sv
// Purpose: host model that issues command write cycles
// Assumes: each call starts on a falling clk edge
// Notes: a released bus shows the inverted last byte, never stale data
`timescale 1ns/1ps
`default_nettype none
module fcsm_host_model (
    input wire logic clk,
    output var fcsm_pkg::fcsm_write_t wr
);
    // ----------------------------------------
    // write cycles
    // ----------------------------------------
    initial begin
        wr = '0;
    end
    // one command byte held for one full cycle
    task automatic send(input logic [7:0] b);
        wr = {1'b1, b};
        @(negedge clk);
    endtask
    // strobe down, data scrambled so nothing reads as a repeat
    task automatic idle();
        wr = {1'b0, ~wr.data};
        @(negedge clk);
    endtask
endmodule
`default_nettype wire

// ===== tb/flash_command_state_machine_tb_top.sv
// Purpose: self-checking bench for the flash command decoder
// Assumes: inputs change on falling edges, one-cycle answer
// Notes: expectations come from the next-state rules only
`timescale 1ns/1ps
`default_nettype none
module flash_command_state_machine_tb_top;
    logic clk;
    logic nrst;
    fcsm_pkg::fcsm_write_t wr;
    fcsm_pkg::fcsm_susp_t susp_in;
    logic susp_load;
    logic [1:0] read_sel, pin_cfg, susp;
    logic ready_flag, seq_error, lock_go, prot_go;
    logic [2:0] phase;
    int error_cnt;
    int compares;
    // ----------------------------------------
    // instances
    // ----------------------------------------
    fcsm_host_model host (.clk(clk), .wr(wr));
    fcsm_core uut (.clk(clk), .nrst(nrst), .wr(wr), .susp_in(susp_in), .susp_load(susp_load),
        .read_sel(read_sel), .pin_cfg(pin_cfg), .ready_flag(ready_flag), .seq_error(seq_error),
        .lock_go(lock_go), .prot_go(prot_go), .phase(phase), .susp(susp));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic seq(input logic [7:0] a, input logic [7:0] b);
        host.send(a);
        host.send(b);
        host.idle();
    endtask
    // one-cycle load of the suspend context
    task automatic load(input fcsm_pkg::fcsm_susp_t s);
        susp_in = s;
        susp_load = 1'b1;
        @(negedge clk);
        susp_load = 1'b0;
    endtask
    task automatic complete_run();
        $display("errors %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    // pin setup with no suspend, good then bad code
    task automatic test_pin_normal();
        seq(8'hb8, 8'h02);
        chk(8'(phase), 8'h00);
        chk(8'(pin_cfg), 8'h02);
        chk(8'(read_sel), 8'(fcsm_pkg::FCSM_DATA_STATUS));
        seq(8'hb8, 8'h07);
        chk(8'(phase), 8'h04);
        chk(8'(seq_error), 8'h01);
    endtask
    // suspended pin setup: edge codes apply, out-of-range keeps suspend
    task automatic test_pin_susp();
        fcsm_pkg::fcsm_susp_t sl[2] = '{fcsm_pkg::FCSM_SUSP_ERASE, fcsm_pkg::FCSM_SUSP_PROG};
        logic [7:0] code;
        for (int i = 0; i < 2; i++) begin
            load(sl[i]);
            code = (i == 0) ? 8'h03 : 8'h00;
            seq(8'hb8, code);
            chk(8'(pin_cfg), code);
            chk(8'(read_sel), 8'(fcsm_pkg::FCSM_DATA_STATUS));
            chk(8'(susp), 8'(sl[i]));
            seq(8'hb8, 8'h04);
            chk(8'(phase), 8'h04);
            chk(8'(susp), 8'(sl[i]));
            chk(8'(pin_cfg), code);
        end
    endtask
    // program-suspended error refuses lock and protection setup
    task automatic test_prog_refuse();
        logic [7:0] cl[2] = '{8'h60, 8'hc0};
        load(fcsm_pkg::FCSM_SUSP_PROG);
        for (int i = 0; i < 2; i++) begin
            seq(8'hb8, 8'h07);
            host.send(cl[i]);
            host.idle();
            chk(8'(phase), 8'h00);
            chk(8'(read_sel), 8'(fcsm_pkg::FCSM_DATA_ARRAY));
            chk(8'(susp), 8'(fcsm_pkg::FCSM_SUSP_PROG));
        end
    endtask
    // every confirm code, then a bad one, plain and erase-suspended
    task automatic test_lock();
        logic [7:0] cl[4] = '{8'hd0, 8'h01, 8'h2f, 8'h03};
        fcsm_pkg::fcsm_susp_t sl[2] = '{fcsm_pkg::FCSM_SUSP_NONE, fcsm_pkg::FCSM_SUSP_ERASE};
        for (int s = 0; s < 2; s++) begin
            load(sl[s]);
            // clear the sticky error left by earlier scenarios
            host.send(8'h50);
            for (int i = 0; i < 4; i++) begin
                host.send(8'h60);
                host.send(cl[i]);
                chk(8'(lock_go), 8'h01);
                host.idle();
                chk(8'(phase), 8'h00);
                chk(8'(seq_error), 8'h00);
            end
            seq(8'h60, 8'h55);
            chk(8'(phase), 8'h04);
            chk(8'(susp), 8'(sl[s]));
        end
    endtask
    // protection setup from the plain error state, then its data cycle
    task automatic test_prot();
        load(fcsm_pkg::FCSM_SUSP_NONE);
        host.send(8'hc0);
        chk(8'(phase), 8'h03);
        host.send(8'h5a);
        chk(8'(prot_go), 8'h01);
        chk(8'(read_sel), 8'(fcsm_pkg::FCSM_DATA_STATUS));
        host.idle();
        chk(8'(prot_go), 8'h00);
        chk(8'(phase), 8'h00);
    endtask
    // error state: ready, status reads, normal command set
    task automatic test_error_cmds();
        logic [7:0] cl[6] = '{8'h70, 8'h50, 8'h90, 8'h98, 8'h12, 8'hb8};
        logic [7:0] el[6] = '{8'h01, 8'h00, 8'h02, 8'h03, 8'h00, 8'h01};
        load(fcsm_pkg::FCSM_SUSP_NONE);
        for (int i = 0; i < 6; i++) begin
            seq(8'hb8, 8'h07);
            chk(8'(ready_flag), 8'h01);
            chk(8'(read_sel), 8'(fcsm_pkg::FCSM_DATA_STATUS));
            host.send(cl[i]);
            host.idle();
            chk(8'(read_sel), el[i]);
            chk(8'(seq_error), (i == 1) ? 8'h00 : 8'h01);
            chk(8'(phase), (i == 5) ? 8'h01 : 8'h00);
        end
    endtask
    // ----------------------------------------
    // clock, main sequence, watchdog
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        nrst = 1'b0;
        susp_in = fcsm_pkg::FCSM_SUSP_NONE;
        susp_load = 1'b0;
        error_cnt = 0;
        compares = 0;
        repeat (20) @(negedge clk);
        chk(8'(phase), 8'h00);
        chk(8'(pin_cfg), 8'h00);
        nrst = 1'b1;
        test_pin_normal();
        test_pin_susp();
        test_prog_refuse();
        test_lock();
        test_prot();
        test_error_cmds();
        complete_run();
    end
    // a hang counts as a mismatch
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        complete_run();
    end
endmodule
`default_nettype wire
